// ==== src/fam_pkg.sv ====
package fam_pkg;

   // ============================================================
   // register map (byte addresses on the apb bus)
   // ============================================================
   localparam logic [7:0]  REG_CMD      = 8'h00; // command launch
   localparam logic [7:0]  REG_ADDR     = 8'h04; // address bytes from host
   localparam logic [7:0]  REG_WDATA    = 8'h08; // program data byte
   localparam logic [7:0]  REG_RDATA    = 8'h0C; // last read byte
   localparam logic [7:0]  REG_BANK     = 8'h10; // bank address register
   localparam logic [7:0]  REG_CFG      = 8'h14; // configuration_register_one
   localparam logic [7:0]  REG_STATUS   = 8'h18; // status_register_one
   localparam logic [7:0]  REG_IRQ_STAT = 8'h1C; // sticky events, w1c
   localparam logic [7:0]  REG_IRQ_MASK = 8'h20; // event enables
   localparam logic [7:0]  REG_PROT     = 8'h24; // sector protection
   localparam logic [7:0]  REG_EFF      = 8'h28; // last formed address

   // ============================================================
   // command codes
   // ============================================================
   localparam logic [7:0]  OP_READ3 = 8'h03; // legacy read
   localparam logic [7:0]  OP_PROG3 = 8'h02; // legacy program
   localparam logic [7:0]  OP_READ4 = 8'h13; // newer read, 32-bit
   localparam logic [7:0]  OP_PROG4 = 8'h12; // newer program, 32-bit
   localparam logic [7:0]  OP_RDID  = 8'h9F; // read_identification_cmd
   localparam logic [7:0]  OP_PARAMS = 8'h5A; // read_discoverable_params_cmd
   localparam logic [7:0]  OP_OTPR  = 8'h4B; // otp read
   localparam logic [7:0]  OP_OTPP  = 8'h42; // otp program
   localparam logic [7:0]  OP_BANKW = 8'h17; // bank register load
   localparam logic [7:0]  OP_CLSR  = 8'h30; // clear status

   // ============================================================
   // field positions and reset values
   // ============================================================
   localparam int          EXT_BIT     = 7;     // extended-address mode
   localparam int          FREEZE_BIT  = 0;     // otp freeze
   localparam int          PERR_BIT    = 6;     // program error
   localparam int          PROT_EN_BIT = 8;     // protection enable
   localparam logic [7:0]  BANK_RST    = 8'h00;
   localparam logic [8:0]  PROT_RST    = 9'h000;
   localparam int          IRQ_DONE    = 0;     // command finished
   localparam int          IRQ_PERR    = 1;     // program refused
   localparam int          IRQ_W       = 2;

   // ============================================================
   // main array and auxiliary spaces
   // ============================================================
   localparam int          SECTOR_LSB     = 18;  // 256-kbyte sectors
   localparam int          SECTOR_W       = 8;   // 256 sectors
   localparam logic [31:0] LAST_SECTOR    = 32'h03FC0000;
   localparam int          OTP_BYTES      = 1024;
   localparam int          OTP_REGION_W   = 5;   // 32-byte regions
   localparam int          OTP_RAND_BYTES = 16;
   localparam int          OTP_LOCK_BASE  = 16;  // lock bytes 010..013
   localparam logic [7:0]  ERASED         = 8'hFF;
   localparam int          ID_BYTES       = 16;
   localparam int          SFDP_HDR_BYTES = 8;

   // identity and factory content: values are arbitrary
   localparam logic [127:0] ID_TABLE   = 128'h0F0E0D0C0B0A09080706050403A1B2C3;
   localparam logic [63:0]  SFDP_HDR   = 64'h00000001000A5A5A;
   localparam logic [127:0] OTP_RANDOM = 128'h13572468ACE0BDF19BADF00D0C0FFEE1;

   typedef enum logic [1:0] {SP_MAIN, SP_ID, SP_SFDP, SP_OTP} fam_space_e;

endpackage

// ==== src/fam_flash_map.sv ====
// Overview of operation
// - byte addresses up to 32 bits accepted
// - legacy 24-bit address uses bank register
// - extended mode: legacy commands take 32 bits
// - newer commands always take 32 bits
// - reset clears bank register, 24-bit mode
// - auxiliary spaces use full 32-bit address
// - 256 uniform 256-kbyte sectors
// - 9Fh reads read-only identification space
// - 5Ah reads parameter space embedding identification
// - 1024-byte otp, 32 lockable regions
// - lowest 16 otp bytes never host-programmable
// - lock bytes 010-013, bit 0 locks
// - locked region rejects any further programming
// - reserved bytes 014-01F stay programmable
// - lock, reserved and user bytes ship FF
// - freeze bit blocks all otp programming
// - freeze stays set until power cycle
// - refused program sets program-error flag
//
// The APB interface to the registers and the register addresses were left to the implementer.
module fam_flash_map (
   input  wire logic                   clock_i,
   input  wire logic                   sys_rst_i,
   input  wire logic                   psel_i,
   input  wire logic                   penable_i,
   input  wire logic                   pwrite_i,
   input  wire logic [7:0]             paddr_i,
   input  wire logic [31:0]            pwdata_i,
   output logic      [31:0]            prdata_o,
   output logic                        pready_o,
   output logic                        pslverr_o,
   output logic                        irq_o,
   output logic      [31:0]            mem_addr_o,
   output logic      [7:0]             mem_sector_o,
   output fam_pkg::fam_space_e         mem_space_o,
   output logic      [7:0]             mem_data_o,
   output logic                        mem_read_o,
   output logic                        mem_prog_o
);
   import fam_pkg::*;

   // ============================================================
   // state
   // ============================================================
   typedef struct packed {
      logic [OTP_BYTES-1:0][7:0] otp;        // one-time-programmable space
      logic [7:0]                bank;       // bank address register
      logic [31:0]               addr;       // address bytes from host
      logic [7:0]                wdata;      // byte to program
      logic [7:0]                rdata;      // byte last read
      logic                      freeze;     // otp freeze
      logic                      perr;       // program error flag
      logic [8:0]                prot;       // enable + first protected
      logic [IRQ_W-1:0]          irq_stat;   // sticky events
      logic [IRQ_W-1:0]          irq_mask;   // event enables
      logic [31:0]               prdata;     // bus read data
      logic                      pready;     // bus answer
      logic                      pslverr;    // unmapped access
      logic                      irq;        // interrupt level
      logic [31:0]               mem_addr;   // formed address
      logic [7:0]                mem_sector; // sector of last main-array mem_addr
      fam_space_e                mem_space;  // space addressed
      logic [7:0]                mem_data;   // byte to main array
      logic                      mem_read;   // main array read strobe
      logic                      mem_prog;   // main array program strobe
   } fam_state_s;

   fam_state_s st_reg;                       // registered state
   fam_state_s st_next;                      // next state

   // ============================================================
   // functions
   // ============================================================
   // register decode, used by the error answer only
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == REG_CMD) || (a == REG_ADDR) || (a == REG_WDATA) ||
                (a == REG_RDATA) || (a == REG_BANK) || (a == REG_CFG) ||
                (a == REG_STATUS) || (a == REG_IRQ_STAT) ||
                (a == REG_IRQ_MASK) || (a == REG_PROT) || (a == REG_EFF);
   endfunction

   // factory content of the otp space at power-on
   function automatic logic [OTP_BYTES-1:0][7:0] otp_delivery();
      logic [OTP_BYTES-1:0][7:0] m;
      m = '0;
      for (int i = 0; i < OTP_BYTES; i++) begin
         m[i] = ERASED;
      end
      for (int i = 0; i < OTP_RAND_BYTES; i++) begin
         m[i] = OTP_RANDOM[i*8 +: 8];
      end
      return m;
   endfunction

   // a region is locked when its bit in the lock bytes reads 0
   function automatic logic otp_locked(
      input logic [OTP_BYTES-1:0][7:0] m,
      input logic [9:0]               a);
      logic [4:0] region;
      logic [7:0] lock_byte;
      region    = a[9:OTP_REGION_W];
      lock_byte = m[OTP_LOCK_BASE + int'(region[4:3])];
      return ~lock_byte[region[2:0]];
   endfunction

   // read-only identification table, host cannot alter it
   function automatic logic [7:0] id_byte(input logic [31:0] a);
      if (a < 32'(ID_BYTES)) begin
         return ID_TABLE[a[3:0]*8 +: 8];
      end
      return ERASED;
   endfunction

   // parameter space: a header, then the identification table
   function automatic logic [7:0] sfdp_byte(input logic [31:0] a);
      logic [31:0] off;
      off = a - 32'(SFDP_HDR_BYTES);
      if (a < 32'(SFDP_HDR_BYTES)) begin
         return SFDP_HDR[a[2:0]*8 +: 8];
      end
      return id_byte(off);
   endfunction

   // ============================================================
   // bus decode
   // ============================================================
   logic        setup_ph;                    // first cycle of a transfer
   logic        wr_go;                       // write takes effect
   logic        cmd_go;                      // command launched
   logic [7:0]  cmd_op;                      // command code
   logic        legacy_cmd;                  // 24-bit capable command
   logic        new_cmd;                     // always 32-bit command
   logic [31:0] eff_addr;                    // formed byte address
   logic [7:0]  eff_sector;                  // sector of that address
   logic        sector_prot;                 // sector is protected
   logic        otp_in_range;                // address inside otp space
   logic        otp_refuse;                  // otp program refused

   assign setup_ph   = psel_i & ~penable_i;
   assign wr_go      = psel_i & penable_i & pwrite_i & st_reg.pready &
                       ~st_reg.pslverr;
   assign cmd_go     = wr_go & (paddr_i == REG_CMD);
   assign cmd_op     = pwdata_i[7:0];
   assign legacy_cmd = (cmd_op == OP_READ3) || (cmd_op == OP_PROG3);
   assign new_cmd    = (cmd_op == OP_READ4) || (cmd_op == OP_PROG4);

   // ============================================================
   // address formation
   // ============================================================
   // address register holds the bytes in arrival order, msb first;
   // in 24-bit mode only the three low bytes were sent
   always_comb begin
      if (legacy_cmd && !st_reg.bank[EXT_BIT]) begin
         eff_addr = {1'b0, st_reg.bank[6:0], st_reg.addr[23:0]};
      end else begin
         // extended mode, newer commands and every side space
         eff_addr = st_reg.addr;
      end
   end

   assign eff_sector   = eff_addr[SECTOR_LSB +: SECTOR_W];
   assign sector_prot  = st_reg.prot[PROT_EN_BIT] &
                         (eff_sector >= st_reg.prot[7:0]);
   assign otp_in_range = (eff_addr[31:10] == 22'h000000);
   // refuse: off the space, frozen, factory bytes, or locked region
   assign otp_refuse   = !otp_in_range || st_reg.freeze ||
                         (eff_addr < 32'(OTP_RAND_BYTES)) ||
                         otp_locked(st_reg.otp, eff_addr[9:0]);

   // ============================================================
   // next-state logic
   // ============================================================
   always_comb begin
      logic [IRQ_W-1:0] ev;                  // events this cycle
      logic [IRQ_W-1:0] clr;                 // w1c clears this cycle
      logic             perr_clr;            // clear-status command
      ev       = '0;
      clr      = '0;
      perr_clr = 1'b0;
      st_next  = st_reg;
      // strobes last one cycle
      st_next.mem_read = 1'b0;
      st_next.mem_prog = 1'b0;
      // zero-wait slave: ready comes in the access phase
      st_next.pready   = setup_ph;
      st_next.pslverr  = setup_ph & ~reg_hit(paddr_i);
      // read data captured in the setup cycle
      if (setup_ph && !pwrite_i) begin
         unique case (paddr_i)
            REG_ADDR:     st_next.prdata = st_reg.addr;
            REG_WDATA:    st_next.prdata = {24'h000000, st_reg.wdata};
            REG_RDATA:    st_next.prdata = {24'h000000, st_reg.rdata};
            REG_BANK:     st_next.prdata = {24'h000000, st_reg.bank};
            REG_CFG:      st_next.prdata = {31'h00000000, st_reg.freeze};
            REG_STATUS:   st_next.prdata = {25'h0000000, st_reg.perr,
                                            6'h00};
            REG_IRQ_STAT: st_next.prdata = {30'h00000000, st_reg.irq_stat};
            REG_IRQ_MASK: st_next.prdata = {30'h00000000, st_reg.irq_mask};
            REG_PROT:     st_next.prdata = {23'h000000, st_reg.prot};
            REG_EFF:      st_next.prdata = st_reg.mem_addr;
            default:      st_next.prdata = 32'h00000000; // cmd, unmapped
         endcase
      end
      // register writes
      if (wr_go) begin
         unique case (paddr_i)
            REG_ADDR:     st_next.addr     = pwdata_i;
            REG_WDATA:    st_next.wdata    = pwdata_i[7:0];
            // freeze can only be set; nothing but reset clears it
            REG_CFG:      st_next.freeze   = st_reg.freeze |
                                             pwdata_i[FREEZE_BIT];
            REG_IRQ_STAT: clr              = pwdata_i[IRQ_W-1:0];
            REG_IRQ_MASK: st_next.irq_mask = pwdata_i[IRQ_W-1:0];
            REG_PROT:     st_next.prot     = pwdata_i[8:0];
            default:      ;                  // read-only or command
         endcase
      end
      // command execution, one cycle each
      if (cmd_go) begin
         ev[IRQ_DONE] = 1'b1;
         unique case (cmd_op)
            OP_READ3, OP_READ4: begin
               st_next.mem_addr   = eff_addr;
               st_next.mem_sector = eff_sector;
               st_next.mem_space  = SP_MAIN;
               st_next.mem_read   = 1'b1;
            end
            OP_PROG3, OP_PROG4: begin
               st_next.mem_addr   = eff_addr;
               st_next.mem_sector = eff_sector;
               st_next.mem_space  = SP_MAIN;
               st_next.mem_data   = st_reg.wdata;
               if (sector_prot) begin
                  ev[IRQ_PERR] = 1'b1;
               end else begin
                  st_next.mem_prog = 1'b1;
               end
            end
            OP_RDID: begin
               st_next.mem_addr  = eff_addr;
               st_next.mem_space = SP_ID;
               st_next.rdata     = id_byte(eff_addr);
            end
            OP_PARAMS: begin
               st_next.mem_addr  = eff_addr;
               st_next.mem_space = SP_SFDP;
               st_next.rdata     = sfdp_byte(eff_addr);
            end
            OP_OTPR: begin
               st_next.mem_addr  = eff_addr;
               st_next.mem_space = SP_OTP;
               st_next.rdata     = otp_in_range ?
                                   st_reg.otp[eff_addr[9:0]] : ERASED;
            end
            OP_OTPP: begin
               st_next.mem_addr  = eff_addr;
               st_next.mem_space = SP_OTP;
               if (otp_refuse) begin
                  ev[IRQ_PERR] = 1'b1;
               end else begin
                  // programming only clears bits; reserved bytes too
                  st_next.otp[eff_addr[9:0]] =
                     st_reg.otp[eff_addr[9:0]] & st_reg.wdata;
               end
            end
            OP_BANKW: st_next.bank = st_reg.wdata;
            OP_CLSR:  perr_clr     = 1'b1;
            default:  ;                      // unknown code: done only
         endcase
      end
      // a new error wins over a clear in the same cycle
      st_next.perr     = (st_reg.perr & ~perr_clr) | ev[IRQ_PERR];
      st_next.irq_stat = (st_reg.irq_stat & ~clr) | ev;
      st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);
      // reset stands for power-on: otp returns to delivery state
      if (sys_rst_i) begin
         st_next        = '0;
         st_next.otp    = otp_delivery();
         st_next.bank   = BANK_RST;
         st_next.prot   = PROT_RST;
         st_next.mem_space = SP_MAIN;
      end
   end

   // ============================================================
   // state register
   // ============================================================
   always_ff @(posedge clock_i) begin
      st_reg <= st_next;
   end

   // outputs straight from the state register
   assign prdata_o     = st_reg.prdata;
   assign pready_o     = st_reg.pready;
   assign pslverr_o    = st_reg.pslverr;
   assign irq_o        = st_reg.irq;
   assign mem_addr_o   = st_reg.mem_addr;
   assign mem_sector_o = st_reg.mem_sector;
   assign mem_space_o  = st_reg.mem_space;
   assign mem_data_o   = st_reg.mem_data;
   assign mem_read_o   = st_reg.mem_read;
   assign mem_prog_o   = st_reg.mem_prog;

   // ============================================================
   // assertions
   // ============================================================
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);

   a_bank_reset_zero: assert property (
      @(posedge clock_i) disable iff (1'b0)
      sys_rst_i |=> (st_reg.bank == 8'h00) && !st_reg.freeze)
      else $error("bank or freeze not cleared by reset");

   a_legacy_bank_addr: assert property (
      (cmd_go && cmd_op == OP_READ3 && !st_reg.bank[EXT_BIT]) |=>
      mem_addr_o == {1'b0, $past(st_reg.bank[6:0]),
                     $past(st_reg.addr[23:0])})
      else $error("legacy address not formed from bank register");

   a_ext_full_addr: assert property (
      (cmd_go && legacy_cmd && st_reg.bank[EXT_BIT]) |=>
      mem_addr_o == $past(st_reg.addr))
      else $error("extended mode did not take full address");

   a_new_cmd_full: assert property (
      (cmd_go && cmd_op == OP_READ4) |=>
      (mem_addr_o == $past(st_reg.addr)) && mem_read_o ##1 !mem_read_o)
      else $error("newer command did not take full address");

   a_sector_index: assert property (
      $rose(mem_read_o) |-> mem_sector_o == mem_addr_o[25:18])
      else $error("sector index does not match address");

   a_freeze_blocks: assert property (
      (cmd_go && cmd_op == OP_OTPP && st_reg.freeze) |=>
      $stable(st_reg.otp) && st_reg.perr)
      else $error("otp programmed while frozen");

   a_random_guard: assert property (
      (cmd_go && cmd_op == OP_OTPP && st_reg.addr < 32'h10) |=>
      st_reg.perr && $stable(st_reg.otp))
      else $error("factory random bytes were programmed");

   a_lock_refuse: assert property (
      (cmd_go && cmd_op == OP_OTPP &&
       otp_locked(st_reg.otp, st_reg.addr[9:0])) |=>
      st_reg.perr && $stable(st_reg.otp))
      else $error("locked otp region was programmed");

   a_bank_load: assert property (
      (cmd_go && cmd_op == OP_BANKW) |=> st_reg.bank == $past(st_reg.wdata))
      else $error("bank register not loaded from program byte");

   a_freeze_sticky: assert property (
      st_reg.freeze |-> st_reg.freeze [*8])
      else $error("freeze dropped without reset");

   a_prot_perr: assert property (
      (cmd_go && cmd_op == OP_PROG4 && sector_prot) |=>
      st_reg.perr && !mem_prog_o)
      else $error("protected sector program not flagged");

   a_irq_level: assert property (
      (|(st_reg.irq_stat & st_reg.irq_mask)) |-> ##[0:1] irq_o)
      else $error("interrupt not raised for unmasked event");

   c_legacy_read: cover property (
      cmd_go && cmd_op == OP_READ3 ##1 mem_read_o);
   c_otp_program: cover property (
      cmd_go && cmd_op == OP_OTPP && !otp_refuse);
   c_lock_refuse: cover property (
      cmd_go && cmd_op == OP_OTPP && otp_locked(st_reg.otp,
      st_reg.addr[9:0]));
   c_irq_raise: cover property ($rose(irq_o));

endmodule

// ==== testbench/fam_mem_model.sv ====
// ============================================================
// array side of the block: counts accepted programs
// ============================================================
module fam_mem_model (
   input  wire logic       clock_i,
   input  wire logic       sys_rst_i,
   input  wire logic       mem_prog_i,
   input  wire logic [7:0] mem_sector_i,
   output int              prog_count_o,
   output logic      [7:0] last_sector_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // a refused program must never reach here, so the count shows it
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         prog_count_o  <= 0;
         last_sector_o <= 8'h00;
      end else if (mem_prog_i === 1'b1) begin
         prog_count_o  <= prog_count_o + 1;
         last_sector_o <= mem_sector_i;
      end
   end
endmodule

// ==== testbench/fam_flash_map_tb_top.sv ====
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin \
 fails++; $display("FAIL %s exp %h got %h", nm, e, s); end end
module fam_flash_map_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fam_pkg::*;
   localparam logic W = 1'b1; // write row
   localparam logic R = 1'b0; // read row, data is the expectation
   logic clock_i = 1'b0, sys_rst_i = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic pready, pslverr, irq, mem_prog, serr;
   logic [7:0] sector, last_sector, mem_data;
   logic [31:0] mem_addr;
   fam_space_e mem_space;
   int fails = 0, total_checks = 0, prog_count;
   // ============================================================
   // command sequence: write rows drive, read rows compare
   // ============================================================
   logic [40:0] rows[$] = '{
      {W,REG_ADDR,32'h12345678}, {W,REG_CMD,24'h0,OP_READ3},
      {R,REG_EFF,32'h00345678},
      {W,REG_WDATA,32'h05}, {W,REG_CMD,24'h0,OP_BANKW},
      {R,REG_BANK,32'h05}, {W,REG_CMD,24'h0,OP_READ3},
      {R,REG_EFF,32'h05345678},
      {W,REG_WDATA,32'h80}, {W,REG_CMD,24'h0,OP_BANKW},
      {W,REG_CMD,24'h0,OP_READ3}, {R,REG_EFF,32'h12345678},
      {W,REG_WDATA,32'h0}, {W,REG_CMD,24'h0,OP_BANKW},
      {W,REG_CMD,24'h0,OP_READ4}, {R,REG_EFF,32'h12345678},
      {W,REG_ADDR,32'h10}, {W,REG_CMD,24'h0,OP_OTPR},
      {R,REG_RDATA,32'hFF},
      {W,REG_ADDR,32'h0}, {W,REG_CMD,24'h0,OP_OTPR},
      {R,REG_RDATA,32'hE1},
      {W,REG_CMD,24'h0,OP_RDID}, {R,REG_RDATA,32'hC3},
      {W,REG_ADDR,32'h8}, {W,REG_CMD,24'h0,OP_PARAMS},
      {R,REG_RDATA,32'hC3},
      {W,REG_ADDR,32'h20}, {W,REG_WDATA,32'h3C}, {W,REG_CMD,24'h0,OP_OTPP},
      {W,REG_CMD,24'h0,OP_OTPR}, {R,REG_RDATA,32'h3C},
      {W,REG_ADDR,32'h0}, {W,REG_WDATA,32'h0}, {W,REG_CMD,24'h0,OP_OTPP},
      {R,REG_STATUS,32'h40}, {W,REG_CMD,24'h0,OP_CLSR},
      {R,REG_STATUS,32'h0},
      {W,REG_ADDR,32'h10}, {W,REG_WDATA,32'hFD}, {W,REG_CMD,24'h0,OP_OTPP},
      {W,REG_ADDR,32'h20}, {W,REG_WDATA,32'h0}, {W,REG_CMD,24'h0,OP_OTPP},
      {R,REG_STATUS,32'h40}, {W,REG_CMD,24'h0,OP_OTPR},
      {R,REG_RDATA,32'h3C}, {W,REG_CMD,24'h0,OP_CLSR},
      {W,REG_ADDR,32'h14}, {W,REG_WDATA,32'h12}, {W,REG_CMD,24'h0,OP_OTPP},
      {W,REG_CMD,24'h0,OP_OTPR}, {R,REG_RDATA,32'h12},
      {W,REG_CFG,32'h1}, {W,REG_CFG,32'h0}, {R,REG_CFG,32'h1},
      {W,REG_ADDR,32'h40}, {W,REG_CMD,24'h0,OP_OTPP},
      {R,REG_STATUS,32'h40}, {W,REG_CMD,24'h0,OP_OTPR},
      {R,REG_RDATA,32'hFF}, {W,REG_CMD,24'h0,OP_CLSR},
      {W,REG_IRQ_STAT,32'h3}, {W,REG_IRQ_MASK,32'h2},
      {W,REG_PROT,32'h1FF}, {W,REG_ADDR,32'h03FC0000},
      {W,REG_CMD,24'h0,OP_PROG4}, {R,REG_STATUS,32'h40}};
   // ============================================================
   // design, array model, clock
   // ============================================================
   fam_flash_map fam_flash_map_inst (.clock_i(clock_i),
      .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .irq_o(irq), .mem_addr_o(mem_addr), .mem_sector_o(sector),
      .mem_space_o(mem_space), .mem_data_o(mem_data), .mem_read_o(),
      .mem_prog_o(mem_prog));
   fam_mem_model fam_mem_model_inst (.clock_i(clock_i),
      .sys_rst_i(sys_rst_i), .mem_prog_i(mem_prog),
      .mem_sector_i(sector), .prog_count_o(prog_count),
      .last_sector_o(last_sector));
   initial begin
      forever #4 clock_i = ~clock_i;
   end
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // a slave that never answers ends the run as a failure
      if (pready !== 1'b1) begin
         fails++;
         summarize();
      end
      rdata = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_i); // idle edge so psel is never driven twice
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // hang guard: whole run is well under this many cycles
   initial begin
      repeat (5000) @(posedge clock_i);
      fails++;
      summarize();
   end
   initial begin
      repeat (2) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      foreach (rows[i]) begin
         apb(rows[i][40], rows[i][39:32], rows[i][31:0]);
         if (!rows[i][40]) `CHK("row read", rows[i][31:0], rdata)
      end
      $display("test table done");
      `CHK("refused prog", 0, prog_count)
      `CHK("irq set", 1'b1, irq)
      apb(W, REG_IRQ_STAT, 32'h2);
      `CHK("irq clear", 1'b0, irq)
      apb(W, REG_ADDR, 32'h03F80000);
      apb(W, REG_CMD, {24'h0, OP_PROG4});
      @(posedge clock_i); // model counts one edge after the strobe
      `CHK("prog count", 1, prog_count)
      `CHK("sector", 8'hFE, last_sector)
      `CHK("mem addr", 32'h03F80000, mem_addr)
      `CHK("mem data", 8'h12, mem_data)
      `CHK("mem space", SP_MAIN, mem_space)
      apb(R, 8'h2C, 32'h0);
      `CHK("unmapped", 1'b1, serr)
      $display("test hand cases done");
      // load a nonzero bank so the reset check can trip
      apb(W, REG_WDATA, 32'h85);
      apb(W, REG_CMD, {24'h0, OP_BANKW});
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      apb(R, REG_BANK, 32'h0);
      `CHK("bank reset", 32'h0, rdata)
      apb(R, REG_CFG, 32'h0);
      `CHK("freeze reset", 32'h0, rdata)
      $display("test reset done");
      summarize();
   end
endmodule
